// ===== hw/revocation_list_parser_updater.sv
// parses an incoming revocation list message and replaces the stored copy
// assumes an external signature verifier and a non-volatile memory write port
`include "rl_consts.svh"

// How it works
// R1 - first generation never exceeds five kilobytes; full size is 5116 bytes.
// R2 - extensions follow the current generation, so older parsers read the front.
// R3 - multi-byte fields are read most significant byte first.
// R4 - leading 4-bit identifier must be 0x9, otherwise the message is ignored.
// R5 - next 4-bit indicator must be 0x1, second generation.
// R6 - sender fills the reserved byte after the indicator with 0x00.
// R7 - 16-bit version is unsigned; larger means newer.
// R8 - generation number starts at 1 and counts the generations present.
// R9 - 24-bit length counts itself, count, reserved, identifiers and 384-byte signature.
// R10 - 10-bit device count then 22 reserved bits that must be zero.
// R11 - one 40-bit identifier per device; list at most 37760 bits.
// R12 - each generation ends in a 3072-bit signature over all preceding bytes.
// R13 - extension 16-bit length counts itself, count, identifiers and signature.
// R14 - extension has 6 zero reserved bits, 10-bit count, then identifiers.
// R15 - compare new version with stored one; proceed only if strictly greater.
// R16 - request signature verification only after the version check succeeds.
// R17 - on passing signature, overwrite the stored message in non-volatile memory.
// R18 - trailing extensions beyond storage capacity may be left unstored.
// R19 - storage holds at least the whole first generation, 5116 bytes.
// R20 - failed version or signature check leaves the stored message unchanged.
module revocation_list_parser_updater
    import rl_pkg::*;
#(
    parameter int STORE_BYTES = `RL_NVM_MIN_BYTES,
    parameter int ADDR_W = 13
)(
    input wire logic ref_clk, // clock, 40 MHz
    input wire logic rstn, // synchronous reset, active low
    input wire logic in_valid, // message byte offered
    input wire logic [7:0] in_data, // message byte
    input wire logic in_last, // final byte of the message
    output logic in_ready, // byte taken when valid and ready
    input wire logic [15:0] stored_version, // version of the stored copy
    output logic vfy_valid, // byte offered to the verifier
    output logic [7:0] vfy_data, // byte to the verifier
    output logic vfy_last, // final byte to the verifier
    input wire logic vfy_ready, // verifier takes the byte
    input wire logic vfy_done, // verifier result strobe
    input wire logic vfy_ok, // signature good, with vfy_done
    output logic nvm_we, // write request to storage
    output logic [ADDR_W-1:0] nvm_addr, // storage byte address
    output logic [7:0] nvm_wdata, // storage byte
    output logic nvm_last, // final byte of the new copy
    input wire logic nvm_ready, // storage takes the write
    output logic upd_done, // one-cycle end-of-message strobe
    output upd_status_e upd_status // outcome, valid with upd_done
);
    if (STORE_BYTES < `RL_NVM_MIN_BYTES || (64'h1 << ADDR_W) < 64'(STORE_BYTES))
    begin : g_bad_params
        $error("storage too small or address too narrow");
    end

    localparam logic [24:0] CAP = 25'(STORE_BYTES);

    upd_state_e state_r;
    upd_state_e state_nxt;
    logic [7:0] stage_mem [STORE_BYTES];
    logic [24:0] pos_r;
    logic [24:0] sec_base_r;
    logic [24:0] sec_end_r;
    logic [24:0] store_len_r;
    logic [24:0] rd_idx_r;
    logic [24:0] wr_idx_r;
    logic [24:0] ext_off;
    logic [23:0] len_r;
    logic [7:0] hold_r;
    logic [7:0] gen_num_r;
    logic [7:0] gens_r;
    logic in_gen1_r;
    logic id_bad_r;
    logic fmt_bad_r;
    logic newer_r;
    logic in_ready_r;
    logic nvm_we_r;
    logic [ADDR_W-1:0] nvm_addr_r;
    logic [7:0] nvm_wdata_r;
    logic nvm_last_r;
    logic upd_done_r;
    upd_status_e upd_status_r;
    logic in_fire;
    logic sec_known;
    logic at_end;
    logic push_fire;

    rl_stream_if #(.W(9)) push_s ();
    rl_stream_if #(.W(9)) pull_s ();

    // expected byte count of a section holding n identifiers
    function automatic logic [24:0] sect_len(input logic [9:0] n, input logic [24:0] fixed);
        return fixed + 25'(n) * `RL_ID_BYTES + `RL_SIG_BYTES;
    endfunction

    assign in_fire = in_valid && in_ready_r;
    assign ext_off = pos_r - sec_base_r;
    assign sec_known = (pos_r > `RL_OFF_RSV_B) && (in_gen1_r || ext_off > `RL_EXT_OFF_LEN_LO);
    assign at_end = sec_known && (pos_r + 25'h0000001 == sec_end_r);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            S_RECV: if (in_fire && in_last) state_nxt = S_CHECK;
            S_CHECK: state_nxt = (id_bad_r || fmt_bad_r || !newer_r) ? S_RECV : S_SEND; // R16
            S_SEND: if (push_fire && push_s.data[8]) state_nxt = S_WAIT;
            S_WAIT: if (vfy_done) state_nxt = vfy_ok ? S_STORE : S_RECV; // R20
            S_STORE: if (nvm_we_r && nvm_ready && nvm_last_r) state_nxt = S_RECV;
            default: state_nxt = S_RECV;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_r <= S_RECV;
            in_ready_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            in_ready_r <= (state_nxt == S_RECV);
        end
    end

    // staging copy; the stored message is untouched until the signature passes
    always_ff @(posedge ref_clk)
    begin
        if (in_fire && pos_r < CAP)
        begin
            stage_mem[pos_r[ADDR_W-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pos_r <= '0;
            sec_base_r <= '0;
            sec_end_r <= '0;
            store_len_r <= '0;
            len_r <= '0;
            hold_r <= 8'h00;
            gen_num_r <= 8'h00;
            gens_r <= 8'h00;
            in_gen1_r <= 1'b1;
            id_bad_r <= 1'b0;
            fmt_bad_r <= 1'b0;
            newer_r <= 1'b0;
        end
        else if (in_fire)
        begin
            pos_r <= in_last ? 25'h0000000 : pos_r + 25'h0000001;
            hold_r <= in_data;
            unique case (pos_r)
                `RL_OFF_ID:
                begin
                    id_bad_r <= (in_data[7:4] != `RL_ID_VAL); // R4
                    fmt_bad_r <= (in_data[3:0] != `RL_GEN_IND_VAL); // R5
                    in_gen1_r <= 1'b1;
                    gens_r <= 8'h01;
                    store_len_r <= '0;
                    newer_r <= 1'b0;
                end
                // strictly greater, unsigned, high byte first
                `RL_OFF_VER_LO: newer_r <= ({hold_r, in_data} > stored_version); // R3 R7 R15
                `RL_OFF_GEN:
                begin
                    gen_num_r <= in_data;
                    if (in_data == 8'h00) fmt_bad_r <= 1'b1; // R8
                end
                `RL_OFF_LEN_HI, `RL_OFF_LEN_MID: len_r <= {len_r[15:0], in_data}; // R3
                `RL_OFF_LEN_LO:
                begin
                    len_r <= {len_r[15:0], in_data};
                    sec_end_r <= `RL_HDR_BYTES + 25'({len_r[15:0], in_data}); // R9
                    if (`RL_HDR_BYTES + 25'({len_r[15:0], in_data}) > `RL_GEN1_MAX_BYTES)
                        fmt_bad_r <= 1'b1; // R1
                end
                `RL_OFF_CNT_HI: ;
                `RL_OFF_CNT_LO:
                begin
                    if (in_data[5:0] != 6'h00) fmt_bad_r <= 1'b1; // R10
                    if ({hold_r, in_data[7:6]} > `RL_MAX_N1) fmt_bad_r <= 1'b1; // R11
                    if (25'(len_r) != sect_len({hold_r, in_data[7:6]}, `RL_GEN1_FIXED))
                        fmt_bad_r <= 1'b1; // R9
                end
                `RL_OFF_RSV_A, `RL_OFF_RSV_B: if (in_data != 8'h00) fmt_bad_r <= 1'b1; // R10
                default:
                begin
                    if (!in_gen1_r)
                    begin
                        unique case (ext_off)
                            `RL_EXT_OFF_LEN_HI: len_r <= {len_r[15:0], in_data}; // R3
                            `RL_EXT_OFF_LEN_LO:
                            begin
                                len_r <= {len_r[15:0], in_data};
                                sec_end_r <= sec_base_r + 25'({hold_r, in_data}); // R13
                            end
                            `RL_EXT_OFF_CNT_HI: if (in_data[7:2] != 6'h00) fmt_bad_r <= 1'b1; // R14
                            `RL_EXT_OFF_CNT_LO:
                                if (25'(len_r[15:0]) != sect_len({hold_r[1:0], in_data}, `RL_EXT_FIXED))
                                    fmt_bad_r <= 1'b1; // R13 R14
                            default: ;
                        endcase
                    end
                end
            endcase
            // keep only whole generations that fit; each ends in its own signature
            if (at_end && sec_end_r <= CAP) store_len_r <= sec_end_r; // R18 R19
            if (at_end && !in_last)
            begin
                sec_base_r <= pos_r + 25'h0000001; // R2
                in_gen1_r <= 1'b0;
                gens_r <= gens_r + 8'h01; // R8
            end
            if (in_last && (!at_end || gens_r != gen_num_r)) fmt_bad_r <= 1'b1; // R8 R12
        end
    end

    // replay of the stored prefix; its last signature covers all bytes before it
    assign push_s.valid = (state_r == S_SEND); // R12 R16
    assign push_s.data = {rd_idx_r == store_len_r - 25'h0000001, stage_mem[rd_idx_r[ADDR_W-1:0]]};
    assign push_fire = push_s.valid && push_s.ready;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || state_r != S_SEND)
        begin
            rd_idx_r <= '0;
        end
        else if (push_fire)
        begin
            rd_idx_r <= rd_idx_r + 25'h0000001;
        end
    end

    rl_skid_buffer #(.W(9)) u_vfy_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_s(push_s),
        .out_s(pull_s)
    );

    assign pull_s.ready = vfy_ready;
    assign vfy_valid = pull_s.valid;
    assign vfy_data = pull_s.data[7:0];
    assign vfy_last = pull_s.data[8];

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || state_r != S_STORE)
        begin
            nvm_we_r <= 1'b0;
            nvm_addr_r <= '0;
            nvm_wdata_r <= 8'h00;
            nvm_last_r <= 1'b0;
            wr_idx_r <= '0;
        end
        else if (!nvm_we_r || nvm_ready)
        begin
            if (nvm_we_r && nvm_last_r)
            begin
                nvm_we_r <= 1'b0;
            end
            else
            begin
                nvm_we_r <= 1'b1; // R17
                nvm_addr_r <= wr_idx_r[ADDR_W-1:0];
                nvm_wdata_r <= stage_mem[wr_idx_r[ADDR_W-1:0]];
                nvm_last_r <= (wr_idx_r == store_len_r - 25'h0000001);
                wr_idx_r <= wr_idx_r + 25'h0000001;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            upd_done_r <= 1'b0;
            upd_status_r <= UPD_STORED;
        end
        else
        begin
            upd_done_r <= 1'b0;
            if (state_r == S_CHECK && state_nxt == S_RECV)
            begin
                upd_done_r <= 1'b1;
                if (id_bad_r) upd_status_r <= UPD_IGNORED; // R4
                else if (fmt_bad_r) upd_status_r <= UPD_BAD_FORMAT;
                else upd_status_r <= UPD_STALE; // R15 R20
            end
            else if (state_r == S_WAIT && vfy_done && !vfy_ok)
            begin
                upd_done_r <= 1'b1;
                upd_status_r <= UPD_BAD_SIG; // R20
            end
            else if (state_r == S_STORE && state_nxt == S_RECV)
            begin
                upd_done_r <= 1'b1;
                upd_status_r <= UPD_STORED; // R17
            end
        end
    end

    assign in_ready = in_ready_r;
    assign nvm_we = nvm_we_r;
    assign nvm_addr = nvm_addr_r;
    assign nvm_wdata = nvm_wdata_r;
    assign nvm_last = nvm_last_r;
    assign upd_done = upd_done_r;
    assign upd_status = upd_status_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_sig_pass;
        state_r == S_WAIT && vfy_done && vfy_ok;
    endsequence
    sequence s_sig_fail;
        state_r == S_WAIT && vfy_done && !vfy_ok;
    endsequence

    a_store_on_pass: assert property (s_sig_pass |=> state_r == S_STORE ##1 nvm_we_r && nvm_addr_r == '0) // R17
        else $error("passing signature did not start the storage write");
    a_fail_discard: assert property (s_sig_fail |=> upd_done_r && upd_status_r == UPD_BAD_SIG ##1 !nvm_we_r[*3]) // R20
        else $error("failed signature was not discarded");
    a_send_after_ver: assert property ($rose(state_r == S_SEND) |-> $past(state_r == S_CHECK) && newer_r && !fmt_bad_r) // R16
        else $error("verification requested without a newer version");
    a_id_ignored: assert property (state_r == S_CHECK && id_bad_r |=> upd_done_r && upd_status_r == UPD_IGNORED && state_r == S_RECV) // R4
        else $error("message with a wrong identifier was not ignored");
    a_version_cmp: assert property (in_fire && pos_r == `RL_OFF_VER_LO |=> newer_r == ({$past(hold_r), $past(in_data)} > $past(stored_version))) // R15
        else $error("version comparison wrong");
    a_count_limit: assert property (in_fire && pos_r == `RL_OFF_CNT_LO && {hold_r, in_data[7:6]} > `RL_MAX_N1 |=> fmt_bad_r) // R11
        else $error("oversized device count accepted");
    a_ext_reserved: assert property (in_fire && !in_gen1_r && pos_r > `RL_OFF_RSV_B && ext_off == `RL_EXT_OFF_CNT_HI && in_data[7:2] != 6'h00 |=> fmt_bad_r) // R14
        else $error("nonzero extension reserved bits accepted");
    a_store_fits: assert property (store_len_r <= CAP && (state_r != S_STORE || store_len_r != '0)) // R19
        else $error("stored length beyond capacity");
endmodule // revocation_list_parser_updater

// ===== hw/rl_consts.svh
// byte offsets, field values and size limits of the revocation list message
// assumes the message arrives one byte at a time, first byte at offset zero
`ifndef RL_CONSTS_SVH
`define RL_CONSTS_SVH

`define RL_ID_VAL 4'h9
`define RL_GEN_IND_VAL 4'h1
`define RL_OFF_ID 25'h0000000
`define RL_OFF_VER_LO 25'h0000003
`define RL_OFF_GEN 25'h0000004
`define RL_OFF_LEN_HI 25'h0000005
`define RL_OFF_LEN_MID 25'h0000006
`define RL_OFF_LEN_LO 25'h0000007
`define RL_OFF_CNT_HI 25'h0000008
`define RL_OFF_CNT_LO 25'h0000009
`define RL_OFF_RSV_A 25'h000000A
`define RL_OFF_RSV_B 25'h000000B
// bytes ahead of the first-generation length field
`define RL_HDR_BYTES 25'h0000005
`define RL_EXT_OFF_LEN_HI 25'h0000000
`define RL_EXT_OFF_LEN_LO 25'h0000001
`define RL_EXT_OFF_CNT_HI 25'h0000002
`define RL_EXT_OFF_CNT_LO 25'h0000003
// length field plus count and reserved bytes
`define RL_GEN1_FIXED 25'h0000007
`define RL_EXT_FIXED 25'h0000004
`define RL_ID_BYTES 25'h0000005
`define RL_SIG_BYTES 25'h0000180
`define RL_MAX_N1 10'h3B0
`define RL_GEN1_MAX_BYTES 25'h00013FC
`define RL_NVM_MIN_BYTES 32'h000013FD

`endif

// ===== hw/rl_pkg.sv
// types shared by the revocation list parser and its bench
// assumes rl_consts.svh is available on the include path
package rl_pkg;

    typedef enum logic [4:0] {
        S_RECV = 5'h01,
        S_CHECK = 5'h02,
        S_SEND = 5'h04,
        S_WAIT = 5'h08,
        S_STORE = 5'h10
    } upd_state_e;

    typedef enum logic [2:0] {
        UPD_STORED = 3'h0,
        UPD_IGNORED = 3'h1,
        UPD_BAD_FORMAT = 3'h2,
        UPD_STALE = 3'h3,
        UPD_BAD_SIG = 3'h4
    } upd_status_e;

endpackage

// ===== hw/rl_skid_buffer.sv
// two-entry buffer: an output register plus a skid register
// assumes a synchronous active-low reset on the shared clock
module rl_skid_buffer #(
    parameter int W = 9
)(
    input wire logic ref_clk, // clock
    input wire logic rstn, // synchronous reset, active low
    rl_stream_if.snk in_s, // filling side
    rl_stream_if.src out_s // draining side
);
    logic [W-1:0] out_q;
    logic [W-1:0] skid_q;
    logic out_v;
    logic skid_v;

    // ready depends only on flops, so no combinational path from the drain
    assign in_s.ready = !skid_v;
    assign out_s.valid = out_v;
    assign out_s.data = out_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            out_v <= 1'b0;
            skid_v <= 1'b0;
            out_q <= '0;
            skid_q <= '0;
        end
        else if (out_s.ready || !out_v)
        begin
            if (skid_v)
            begin
                out_q <= skid_q;
                out_v <= 1'b1;
                skid_v <= 1'b0;
            end
            else
            begin
                out_q <= in_s.data;
                out_v <= in_s.valid;
            end
        end
        else if (in_s.valid && !skid_v)
        begin
            skid_q <= in_s.data;
            skid_v <= 1'b1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_buf_hold_word: assert property (out_v && !out_s.ready |=> out_v && $stable(out_q))
        else $error("buffer dropped or changed a stalled word");
    a_buf_full_stall: assert property (skid_v && !out_s.ready |=> skid_v && !in_s.ready)
        else $error("buffer accepted a word while full");
endmodule // rl_skid_buffer

// ===== hw/rl_stream_if.sv
// valid/ready byte stream between the parser and its output buffer
// assumes both ends share one clock
interface rl_stream_if #(
    parameter int W = 9
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== test/rl_far_side.sv
// far-side model: signature verifier and non-volatile byte store
// assumes the parser's verifier and storage ports on one shared clock
module rl_far_side #(
    parameter int SEED = 97
)(
    input wire logic ref_clk, // clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic sig_good, // verdict the bench wants returned
    input wire logic vfy_valid, // replay byte offered
    input wire logic [7:0] vfy_data, // replay byte
    input wire logic vfy_last, // final replay byte
    output logic vfy_ready, // verifier takes byte
    output logic vfy_done, // verdict strobe
    output logic vfy_ok, // verdict, with vfy_done
    input wire logic nvm_we, // write request
    input wire logic [12:0] nvm_addr, // write address
    input wire logic [7:0] nvm_wdata, // write byte
    input wire logic nvm_last, // final write
    output logic nvm_ready // storage takes write
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] vfy_q[$];
    logic [7:0] nvm_q[$];
    int vfy_last_idx = -1;
    int nvm_last_idx = -1;
    int addr_bad = 0;
    int seed = SEED;
    int wait_n = -1;

    initial
    begin
        vfy_ready = 1'b0;
        vfy_done = 1'b0;
        vfy_ok = 1'b0;
        nvm_ready = 1'b0;
    end

    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            vfy_ready <= 1'b0;
            vfy_done <= 1'b0;
            vfy_ok <= 1'b0;
            nvm_ready <= 1'b0;
            wait_n = -1;
        end
        else
        begin
            // random stalls on both sides so the buffer must hold its words
            vfy_ready <= ($random(seed) & 3) != 0;
            nvm_ready <= ($random(seed) & 3) != 0;
            if (vfy_valid && vfy_ready)
            begin
                vfy_q.push_back(vfy_data);
                if (vfy_last)
                begin
                    vfy_last_idx = vfy_q.size() - 1;
                    wait_n = $random(seed) & 3;
                end
            end
            vfy_done <= wait_n == 0;
            // outside the strobe the verdict line shows the wrong answer
            vfy_ok <= (wait_n == 0) ? sig_good : ~sig_good;
            if (wait_n >= 0)
                wait_n = wait_n - 1;
            if (nvm_we && nvm_ready)
            begin
                if (nvm_addr != 13'(nvm_q.size()))
                    addr_bad = addr_bad + 1;
                nvm_q.push_back(nvm_wdata);
                if (nvm_last)
                    nvm_last_idx = nvm_q.size() - 1;
            end
        end
    end
endmodule // rl_far_side

// ===== test/tb_revocation_list_parser_updater.sv
// self-checking bench for the revocation list parser and updater
// assumes the far-side model on the verifier and storage ports
module tb_revocation_list_parser_updater import rl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic in_valid = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic in_last = 1'b0;
    logic [15:0] stored_version = 16'h0000;
    logic sig_good = 1'b1;
    logic in_ready, vfy_valid, vfy_last, vfy_ready, vfy_done, vfy_ok;
    logic nvm_we, nvm_last, nvm_ready, upd_done;
    logic [7:0] vfy_data, nvm_wdata;
    logic [12:0] nvm_addr;
    upd_status_e upd_status;
    int err_count = 0;
    int n_compared = 0;
    int seed = 6896;
    int store_len;
    logic [7:0] msg[$];

    always #12.5 ref_clk = ~ref_clk;

    revocation_list_parser_updater revocation_list_parser_updater_inst (.ref_clk, .rstn,
        .in_valid, .in_data, .in_last, .in_ready, .stored_version, .vfy_valid, .vfy_data,
        .vfy_last, .vfy_ready, .vfy_done, .vfy_ok, .nvm_we, .nvm_addr, .nvm_wdata, .nvm_last,
        .nvm_ready, .upd_done, .upd_status);

    rl_far_side rl_far_side_inst (.ref_clk, .rstn, .sig_good, .vfy_valid, .vfy_data,
        .vfy_last, .vfy_ready, .vfy_done, .vfy_ok, .nvm_we, .nvm_addr, .nvm_wdata, .nvm_last,
        .nvm_ready);

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic put(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            msg.push_back(v[8*i +: 8]);
    endtask

    task automatic build(input logic [3:0] id, input logic [3:0] ind, input logic [15:0] ver,
        input logic [7:0] gen, input int n1, input int n_ext, input int len_adj,
        input bit rsv_bad);
        int n2;
        msg.delete();
        put({24'h0, id, ind}, 1);
        put(32'h0, 1);
        put({16'h0, ver}, 2);
        put({24'h0, gen}, 1);
        put(7 + 5 * n1 + 384 + len_adj, 3);
        put({n1[9:0], 6'h00, 8'h00, (rsv_bad && n_ext == 0) ? 8'h01 : 8'h00}, 4);
        repeat (5 * n1 + 384)
            put($random(seed), 1);
        store_len = msg.size();
        for (int e = 0; e < n_ext; e++)
        begin
            n2 = $random(seed) & 7;
            put(4 + 5 * n2 + 384, 2);
            // bad reserved bits land in the extension when one is present
            put(rsv_bad ? n2 | 32'h0400 : n2, 2);
            repeat (5 * n2 + 384)
                put($random(seed), 1);
            // only whole generations that fit the store are kept
            if (msg.size() <= 5117)
                store_len = msg.size();
        end
    endtask

    function automatic upd_status_e expect_status(input logic [3:0] id, input bit fmt,
        input logic [15:0] v, input logic [15:0] sv, input bit ok);
        if (id != 4'h9)
            return UPD_IGNORED;
        if (!fmt)
            return UPD_BAD_FORMAT;
        if (v <= sv)
            return UPD_STALE;
        return ok ? UPD_STORED : UPD_BAD_SIG;
    endfunction

    task automatic send();
        int n;
        for (int i = 0; i < msg.size(); i++)
        begin
            if (($random(seed) & 3) == 0)
            begin
                in_valid <= 1'b0;
                in_data <= 8'($random(seed));
                @(posedge ref_clk);
            end
            in_valid <= 1'b1;
            in_data <= msg[i];
            in_last <= i == msg.size() - 1;
            n = 0;
            do
            begin
                @(posedge ref_clk);
                n++;
            end
            while (in_ready !== 1'b1 && n < 100);
            if (n >= 100)
            begin
                err_count++;
                end_of_test();
            end
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
    endtask

    task automatic run(input logic [3:0] id, input logic [3:0] ind, input logic [15:0] ver,
        input logic [15:0] sv, input logic [7:0] gen, input int n1, input int n_ext,
        input int len_adj, input bit rsv_bad, input bit ok);
        bit fmt;
        int n;
        int nv;
        int ns;
        upd_status_e exp;
        build(id, ind, ver, gen, n1, n_ext, len_adj, rsv_bad);
        fmt = ind == 4'h1 && gen == n_ext + 1 && len_adj == 0 && !rsv_bad && n1 <= 944;
        exp = expect_status(id, fmt, ver, sv, ok);
        rl_far_side_inst.vfy_q.delete();
        rl_far_side_inst.nvm_q.delete();
        rl_far_side_inst.vfy_last_idx = -1;
        rl_far_side_inst.nvm_last_idx = -1;
        stored_version <= sv;
        sig_good <= ok;
        send();
        n = 0;
        while (upd_done !== 1'b1 && n < 40000)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 40000)
        begin
            err_count++;
            end_of_test();
        end
        check(upd_status, exp);
        nv = (exp == UPD_STORED || exp == UPD_BAD_SIG) ? store_len : 0;
        ns = (exp == UPD_STORED) ? store_len : 0;
        check(rl_far_side_inst.vfy_q.size(), nv);
        check(rl_far_side_inst.vfy_last_idx, nv - 1);
        check(rl_far_side_inst.nvm_q.size(), ns);
        check(rl_far_side_inst.nvm_last_idx, ns - 1);
        check(rl_far_side_inst.addr_bad, 0);
        for (int i = 0; i < nv; i++)
            check(rl_far_side_inst.vfy_q[i], msg[i]);
        for (int i = 0; i < ns; i++)
            check(rl_far_side_inst.nvm_q[i], msg[i]);
    endtask

    initial
    begin
        logic [15:0] v;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int id = 0; id < 16; id++)
        begin
            v = 16'($random(seed)) & 16'h7FFF;
            run(4'(id), 4'h1, v + 16'h0001, v, 8'h01, $random(seed) & 7, 0, 0, 0, 1);
        end
        run(4'h8, 4'h2, 16'h0001, 16'h0005, 8'h00, 3, 0, 1, 1, 1);
        run(4'h9, 4'h2, 16'h0001, 16'h0005, 8'h01, 2, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0010, 16'h0005, 8'h00, 2, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0010, 16'h0005, 8'h02, 2, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0010, 16'h0005, 8'h01, 2, 0, 1, 0, 1);
        run(4'h9, 4'h1, 16'h0010, 16'h0005, 8'h01, 2, 0, -1, 0, 1);
        run(4'h9, 4'h1, 16'h0010, 16'h0005, 8'h01, 2, 0, 0, 1, 1);
        run(4'h9, 4'h1, 16'h0010, 16'h0005, 8'h01, 945, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0005, 16'h0005, 8'h01, 1, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0000, 16'hFFFF, 8'h01, 1, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h8000, 16'h7FFF, 8'h01, 4, 0, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0200, 16'h0100, 8'h01, 5, 0, 0, 0, 0);
        run(4'h9, 4'h1, 16'h0300, 16'h0200, 8'h02, 3, 1, 0, 0, 1);
        run(4'h9, 4'h1, 16'h0400, 16'h0300, 8'h03, 1, 2, 0, 0, 0);
        run(4'h9, 4'h1, 16'h0600, 16'h0500, 8'h02, 2, 1, 0, 1, 1);
        run(4'h9, 4'h1, 16'h0500, 16'h0400, 8'h02, 944, 1, 0, 0, 1);
        end_of_test();
    end
endmodule // tb_revocation_list_parser_updater
